// >>> mtcs_pkg.sv
package mtcs_pkg;
  // ----------------------------------------------------------------
  // Character layout
  // ----------------------------------------------------------------
  localparam int          CHAR_W      = 6;
  localparam int          CHK_BIT     = 6;
  localparam logic [5:0]  TAPE_MARK   = 6'h0F;

  // ----------------------------------------------------------------
  // Timing figures
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int WR_DELAY_US      = 10;
  localparam int ERASE_DELAY_US   = 40;
  localparam int RD_DELAY_US      = 10;
  localparam int EOR_GAP_US       = 4;
  localparam int FWD_NUDGE_US     = 2;
  localparam int DRIVE_NS         = 100;
  localparam int WR_DELAY_CYC     = WR_DELAY_US * CLK_MHZ;
  localparam int ERASE_DELAY_CYC  = ERASE_DELAY_US * CLK_MHZ;
  localparam int RD_DELAY_CYC     = RD_DELAY_US * CLK_MHZ;
  localparam int EOR_GAP_CYC      = EOR_GAP_US * CLK_MHZ;
  localparam int FWD_NUDGE_CYC    = FWD_NUDGE_US * CLK_MHZ;
  localparam int DRIVE_DIV        = (DRIVE_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Clock phases
  // ----------------------------------------------------------------
  localparam logic [3:0]  WC_LOAD     = 4'h1;
  localparam logic [3:0]  WC_STROBE   = 4'h5;
  localparam logic [3:0]  WC_LAST     = 4'hF;
  localparam logic [3:0]  RC_CHECK    = 4'h3;
  localparam logic [3:0]  RC_LOAD     = 4'h6;
  localparam logic [3:0]  RC_LAST     = 4'hA;

  typedef enum logic [3:0] {
    MT_IDLE, MT_DELAY, MT_WRITE, MT_WR_END, MT_READ,
    MT_BS_FWD, MT_BS_RUN, MT_STOP
  } mt_state_e;
endpackage

// >>> mtcs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Data moves one character at a time: six BCD bits plus check.
// - Check bit gives odd or even count per current parity mode.
// - Character bits pass through unchanged; no code translation here.
// - Write asserts go, runs write delay, then starts write clock.
// - System holds data during load; loaded register drives tape data.
// - Later write clock phase becomes the write strobe to the drive.
// - Write clock repeats until disconnect; then check char and stop.
// - Read asserts go, runs read delay, then enables read amplifiers.
// - Each tape character captured into noise register A and low register B.
// - Each character runs read clock one cycle, stops after last phase.
// - A parity checked; load read-write register from B if A bad.
// - Each read cycle restarts end-of-record timer; expiry ends record.
// - Write runs read check without loading; write ends after read ends.
// - Backspace from write status: nudge forward, read status, backward.
// - Backspace runs read clock and timer only; ends forward status.
// - Tape mark forces 8421 pattern and starts disconnect immediately.
// - First read cycle with tape mark in A raises tape-mark output.
// - Rewind flag drives rewind until drive reports rewind status.
// - Rewind-unload flag rewinds, arms unload, clears on rewind status.
// - Parity checks default even; odd request switches them to odd.
// - Erase request makes next write use longer delay.
// - Every detected error sets one summary error flag output.
module mtcs_top
  import mtcs_pkg::*;
#(
  parameter int WR_DLY  = WR_DELAY_CYC,
  parameter int ER_DLY  = ERASE_DELAY_CYC,
  parameter int RD_DLY  = RD_DELAY_CYC,
  parameter int EOR_DLY = EOR_GAP_CYC,
  parameter int FWD_DLY = FWD_NUDGE_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        write_call_i,
  input  wire logic        read_call_i,
  input  wire logic        backspace_call_i,
  input  wire logic        tape_mark_call_i,
  input  wire logic        rewind_call_i,
  input  wire logic        rewind_unload_call_i,
  input  wire logic        disconnect_call_i,
  input  wire logic        odd_call_i,
  input  wire logic        erase_call_i,
  input  wire logic [6:0]  sys_data_i,
  input  wire logic [6:0]  tape_rd_a_i,
  input  wire logic [6:0]  tape_rd_b_i,
  input  wire logic        tape_char_i,
  input  wire logic        drive_write_status_i,
  input  wire logic        drive_rewind_status_i,
  output logic             go_o,
  output logic             backward_o,
  output logic             write_status_o,
  output logic             write_strobe_o,
  output logic [6:0]       tape_wr_data_o,
  output logic             amp_enable_o,
  output logic [6:0]       sys_data_o,
  output logic             sys_data_valid_o,
  output logic             first_tm_o,
  output logic             rewind_o,
  output logic             unload_o,
  output logic             error_o,
  output logic             busy_o
);
  localparam int CW = 16;

  // ----------------------------------------------------------------
  // Parity helper
  // ----------------------------------------------------------------
  function automatic logic char_parity_bad(input logic [6:0] c,
                                           input logic odd);
    char_parity_bad = (^c) != odd;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers (three stages; change once stages 2 and 3 agree)
  // ----------------------------------------------------------------
  logic [2:0] chr_s_q, chr_s_d, rws_s_q, rws_s_d, wst_s_q, wst_s_d;
  logic       chr_f_q, chr_f_d, rws_f_q, rws_f_d, wst_f_q, wst_f_d;
  always_comb begin
    chr_s_d = {chr_s_q[1:0], tape_char_i};
    rws_s_d = {rws_s_q[1:0], drive_rewind_status_i};
    wst_s_d = {wst_s_q[1:0], drive_write_status_i};
    chr_f_d = (chr_s_q[1] == chr_s_q[2]) ? chr_s_q[2] : chr_f_q;
    rws_f_d = (rws_s_q[1] == rws_s_q[2]) ? rws_s_q[2] : rws_f_q;
    wst_f_d = (wst_s_q[1] == wst_s_q[2]) ? wst_s_q[2] : wst_f_q;
  end
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      chr_s_q <= 3'h0;
      rws_s_q <= 3'h0;
      wst_s_q <= 3'h0;
      chr_f_q <= 1'b0;
      rws_f_q <= 1'b0;
      wst_f_q <= 1'b0;
    end else begin
      chr_s_q <= chr_s_d;
      rws_s_q <= rws_s_d;
      wst_s_q <= wst_s_d;
      chr_f_q <= chr_f_d;
      rws_f_q <= rws_f_d;
      wst_f_q <= wst_f_d;
    end
  end
  logic chr_rise;
  assign chr_rise = chr_f_d & ~chr_f_q;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  mt_state_e   st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d, eor_q, eor_d;
  logic [7:0]  div_q, div_d;
  logic        tick;
  logic [3:0]  wc_q, wc_d, rc_q, rc_d;
  logic        rc_run_q, rc_run_d, wr_op_q, wr_op_d, bs_op_q, bs_op_d;
  logic        disc_q, disc_d, tm_op_q, tm_op_d, chk_q, chk_d;
  logic        first_q, first_d, eor_run_q, eor_run_d;
  logic        odd_q, odd_d, erase_q, erase_d, err_q, err_d;
  logic        rw_q, rw_d, rwu_q, rwu_d, unl_q, unl_d;
  logic [6:0]  ra_q, ra_d, rb_q, rb_d, rwreg_q, rwreg_d, lrc_q, lrc_d;
  logic        go_q, go_d, bk_q, bk_d, wst_q, wst_d, ws_q, ws_d;
  logic        amp_q, amp_d, sv_q, sv_d, ftm_q, ftm_d;
  logic        a_bad;

  assign tick  = (div_q == 8'(DRIVE_DIV - 1));
  assign a_bad = char_parity_bad(ra_q, odd_q);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    eor_d = eor_q;
    wc_d = wc_q;
    rc_d = rc_q;
    div_d = tick ? 8'h00 : div_q + 8'h01;
    rc_run_d = rc_run_q;
    wr_op_d = wr_op_q;
    bs_op_d = bs_op_q;
    disc_d = disc_q;
    tm_op_d = tm_op_q;
    chk_d = chk_q;
    first_d = first_q;
    eor_run_d = eor_run_q;
    odd_d = odd_q;
    erase_d = erase_q;
    err_d = err_q;
    rw_d = rw_q;
    rwu_d = rwu_q;
    unl_d = unl_q;
    ra_d = ra_q;
    rb_d = rb_q;
    rwreg_d = rwreg_q;
    lrc_d = lrc_q;
    go_d = go_q;
    bk_d = bk_q;
    wst_d = wst_q;
    ws_d = 1'b0;
    amp_d = amp_q;
    sv_d = 1'b0;
    ftm_d = ftm_q;

    if (odd_call_i) odd_d = 1'b1;
    if (erase_call_i) erase_d = 1'b1;
    if (rewind_call_i) rw_d = 1'b1;
    else if (rws_f_q) rw_d = 1'b0;
    if (rewind_unload_call_i) begin
      rwu_d = 1'b1;
      unl_d = 1'b1;
    end else if (rws_f_q) rwu_d = 1'b0;
    if (disconnect_call_i && wr_op_q) disc_d = 1'b1;

    // Read side: capture both registers and run one read cycle per char
    if (amp_q && chr_rise) begin
      ra_d = tape_rd_a_i;
      rb_d = tape_rd_b_i;
      rc_run_d = 1'b1;
      rc_d = 4'h0;
      eor_run_d = 1'b0;
      if (rc_run_q) err_d = 1'b1;
    end else if (rc_run_q && tick) begin
      rc_d = rc_q + 4'h1;
      if (rc_q == RC_CHECK && !bs_op_q) begin
        // The check character carries no set parity of its own
        if (a_bad && wr_op_q && !chk_q) err_d = 1'b1;
        if (wr_op_q && ra_q != rb_q) err_d = 1'b1;
        if (!wr_op_q) lrc_d = lrc_q ^ ra_q;
        if (first_q && ra_q[5:0] == TAPE_MARK)
          ftm_d = 1'b1;
      end
      if (rc_q == RC_LOAD && !wr_op_q && !bs_op_q) begin
        rwreg_d = a_bad ? rb_q : ra_q;
        sv_d = 1'b1;
        if (char_parity_bad(a_bad ? rb_q : ra_q, odd_q))
          err_d = 1'b1;
      end
      if (rc_q == RC_LAST) begin
        rc_run_d = 1'b0;
        first_d = 1'b0;
        eor_run_d = 1'b1;
        eor_d = '0;
      end
    end
    if (eor_run_q) eor_d = eor_q + 1'b1;

    case (st_q)
      MT_IDLE: begin
        wc_d = 4'h0;
        if (write_call_i || tape_mark_call_i) begin
          go_d = 1'b1;
          wst_d = 1'b1; wr_op_d = 1'b1; bk_d = 1'b0;
          tm_op_d = tape_mark_call_i;
          disc_d = tape_mark_call_i;
          cnt_d = CW'(erase_q ? ER_DLY : WR_DLY);
          erase_d = 1'b0; lrc_d = '0; chk_d = 1'b0; first_d = 1'b1;
          st_d = MT_DELAY;
        end else if (read_call_i) begin
          go_d = 1'b1; wst_d = 1'b0; bk_d = 1'b0;
          wr_op_d = 1'b0; bs_op_d = 1'b0; first_d = 1'b1; lrc_d = '0;
          ftm_d = 1'b0;
          cnt_d = CW'(RD_DLY);
          st_d = MT_DELAY;
        end else if (backspace_call_i) begin
          bs_op_d = 1'b1; wr_op_d = 1'b0; first_d = 1'b0;
          if (wst_f_q) begin
            go_d = 1'b1; bk_d = 1'b0;
            cnt_d = CW'(FWD_DLY);
            st_d = MT_BS_FWD;
          end else begin
            wst_d = 1'b0; bk_d = 1'b1; go_d = 1'b1;
            cnt_d = CW'(RD_DLY);
            st_d = MT_DELAY;
          end
        end
      end
      MT_BS_FWD: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0) begin
          wst_d = 1'b0;
          bk_d = 1'b1;
          cnt_d = CW'(RD_DLY);
          st_d = MT_DELAY;
        end
      end
      MT_DELAY: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0) begin
          amp_d = 1'b1;
          eor_run_d = 1'b0;
          st_d = wr_op_q ? MT_WRITE : (bs_op_q ? MT_BS_RUN : MT_READ);
        end
      end
      MT_WRITE: begin
        if (tick) begin
          wc_d = wc_q + 4'h1;
          if (wc_q == WC_LOAD)
            rwreg_d = tm_op_q ? {1'b0, TAPE_MARK} : sys_data_i;
          if (wc_q == WC_STROBE) begin
            ws_d = 1'b1;
            if (char_parity_bad(rwreg_q, odd_q)) err_d = 1'b1;
          end
          if (wc_q == WC_LAST && disc_q) begin
            rwreg_d = lrc_q;
            chk_d = 1'b1;
            st_d = MT_WR_END;
          end
        end
        if (tick && wc_q == WC_STROBE) lrc_d = lrc_q ^ rwreg_q;
      end
      MT_WR_END: begin
        if (tick) begin
          wc_d = wc_q + 4'h1;
          if (wc_q == WC_STROBE) ws_d = chk_q;
          if (wc_q == WC_LAST) chk_d = 1'b0;
        end
        // Wait for the read-back to run dry before stopping
        if (!chk_q && !rc_run_q && eor_run_q && eor_q >= CW'(EOR_DLY))
          st_d = MT_STOP;
      end
      MT_READ, MT_BS_RUN: begin
        if (eor_run_q && eor_q >= CW'(EOR_DLY)) begin
          if (!bs_op_q && lrc_q != '0) err_d = 1'b1;
          st_d = MT_STOP;
        end
      end
      MT_STOP: begin
        go_d = 1'b0; amp_d = 1'b0; bk_d = 1'b0;
        wr_op_d = 1'b0; bs_op_d = 1'b0; disc_d = 1'b0; tm_op_d = 1'b0;
        rc_run_d = 1'b0; eor_run_d = 1'b0; wc_d = 4'h0; first_d = 1'b0;
        st_d = MT_IDLE;
      end
      default: st_d = MT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_q <= MT_IDLE;
      cnt_q <= '0;
      eor_q <= '0;
      div_q <= 8'h00;
      wc_q <= 4'h0;
      rc_q <= 4'h0;
      rc_run_q <= 1'b0;
      wr_op_q <= 1'b0;
      bs_op_q <= 1'b0;
      disc_q <= 1'b0;
      tm_op_q <= 1'b0;
      chk_q <= 1'b0;
      first_q <= 1'b0;
      eor_run_q <= 1'b0;
      odd_q <= 1'b0;
      erase_q <= 1'b0;
      err_q <= 1'b0;
      rw_q <= 1'b0;
      rwu_q <= 1'b0;
      unl_q <= 1'b0;
      ra_q <= 7'h00;
      rb_q <= 7'h00;
      rwreg_q <= 7'h00;
      lrc_q <= 7'h00;
      go_q <= 1'b0;
      bk_q <= 1'b0;
      wst_q <= 1'b0;
      ws_q <= 1'b0;
      amp_q <= 1'b0;
      sv_q <= 1'b0;
      ftm_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      eor_q <= eor_d;
      div_q <= div_d;
      wc_q <= wc_d;
      rc_q <= rc_d;
      rc_run_q <= rc_run_d;
      wr_op_q <= wr_op_d;
      bs_op_q <= bs_op_d;
      disc_q <= disc_d;
      tm_op_q <= tm_op_d;
      chk_q <= chk_d;
      first_q <= first_d;
      eor_run_q <= eor_run_d;
      odd_q <= odd_d;
      erase_q <= erase_d;
      err_q <= err_d;
      rw_q <= rw_d;
      rwu_q <= rwu_d;
      unl_q <= unl_d;
      ra_q <= ra_d;
      rb_q <= rb_d;
      rwreg_q <= rwreg_d;
      lrc_q <= lrc_d;
      go_q <= go_d;
      bk_q <= bk_d;
      wst_q <= wst_d;
      ws_q <= ws_d;
      amp_q <= amp_d;
      sv_q <= sv_d;
      ftm_q <= ftm_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from flip-flops; rewind_o and busy_o are decoded from them
  // ----------------------------------------------------------------
  assign go_o             = go_q;
  assign backward_o       = bk_q;
  assign write_status_o   = wst_q;
  assign write_strobe_o   = ws_q;
  assign tape_wr_data_o   = rwreg_q;
  assign amp_enable_o     = amp_q;
  assign sys_data_o       = rwreg_q;
  assign sys_data_valid_o = sv_q;
  assign first_tm_o       = ftm_q;
  assign rewind_o         = rw_q | rwu_q;
  assign unload_o         = unl_q;
  assign error_o          = err_q;
  assign busy_o           = (st_q != MT_IDLE);
endmodule

// >>> mtcs_checker.sv
`timescale 1ns/1ps
module mtcs_checker (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic       write_call_i,
  input wire logic       read_call_i,
  input wire logic       rewind_call_i,
  input wire logic       drive_rewind_status_i,
  input wire logic       go_o,
  input wire logic       backward_o,
  input wire logic       write_status_o,
  input wire logic       write_strobe_o,
  input wire logic [6:0] tape_wr_data_o,
  input wire logic       amp_enable_o,
  input wire logic       sys_data_valid_o,
  input wire logic       rewind_o,
  input wire logic       error_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------
  // Sequencer properties
  // ----------
  sequence s_wr_take; write_call_i && !busy_o; endsequence
  // Rewind call takes priority over the synchronised status, so the set holds even without a quiet status
  sequence s_rew_quiet; (!drive_rewind_status_i)[*4] ##0 rewind_call_i;
  endsequence
  property p_wr_go; s_wr_take |=> go_o && write_status_o && busy_o;
  endproperty
  a_wr_go: assert property (p_wr_go)
    else $error("Write call gave no go");
  property p_wr_quiet; s_wr_take |=> (!write_strobe_o && !amp_enable_o)[*8];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("Write began before its delay");
  property p_rd_go; read_call_i && !busy_o |=> go_o && !amp_enable_o;
  endproperty
  a_rd_go: assert property (p_rd_go)
    else $error("Read call gave no go or early amplifiers");
  property p_strb_data;
    write_strobe_o |-> $stable(tape_wr_data_o) && go_o && write_status_o;
  endproperty
  a_strb_data: assert property (p_strb_data)
    else $error("Strobe without steady data or write status");
  property p_strb_gap; write_strobe_o |=> (!write_strobe_o)[*8]; endproperty
  a_strb_gap: assert property (p_strb_gap)
    else $error("Write strobes too close");
  property p_val_read;
    sys_data_valid_o |-> !write_status_o && !backward_o ##1 !sys_data_valid_o;
  endproperty
  a_val_read: assert property (p_val_read)
    else $error("Character delivered outside a forward read");
  property p_back_rd; backward_o |-> !write_status_o; endproperty
  a_back_rd: assert property (p_back_rd)
    else $error("Backward motion in write status");
  property p_rew_set; s_rew_quiet |=> rewind_o; endproperty
  a_rew_set: assert property (p_rew_set)
    else $error("Rewind call did not set rewind");
  property p_err_hold; error_o |=> error_o; endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("Summary error dropped");
endmodule

bind mtcs_top mtcs_checker u_chk (.core_clk_i, .nrst_i, .write_call_i,
  .read_call_i, .rewind_call_i, .drive_rewind_status_i, .go_o, .backward_o,
  .write_status_o, .write_strobe_o, .tape_wr_data_o, .amp_enable_o,
  .sys_data_valid_o, .rewind_o, .error_o, .busy_o);

// >>> mtcs_drive_model.sv
`timescale 1ns/1ps
module mtcs_drive_model (
  input  wire logic       clk_i,
  input  wire logic       write_status_i,
  input  wire logic       write_strobe_i,
  input  wire logic [6:0] wr_data_i,
  input  wire logic       rewind_i,
  input  wire logic       send_i,
  input  wire logic [6:0] send_a_i,
  input  wire logic [6:0] send_b_i,
  output logic [6:0]      rd_a_o,
  output logic [6:0]      rd_b_o,
  output logic            char_o,
  output logic            wstat_o,
  output logic            rstat_o
);
  logic [6:0] a_q    = 7'h00;
  logic [6:0] b_q    = 7'h00;
  logic [5:0] ecnt_q = 6'h00;
  logic [5:0] rcnt_q = 6'h00;
  logic [3:0] pcnt_q = 4'h0;
  initial {rd_a_o, rd_b_o, char_o, wstat_o, rstat_o} = '0;
  // ----------
  // Drive behaviour
  // ----------
  always @(posedge clk_i) begin
    wstat_o <= write_status_i;
    if (write_strobe_i) begin // Read head returns each written char
      {a_q, b_q, ecnt_q} <= {wr_data_i, wr_data_i, 6'h14};
    end else if (send_i) begin
      {a_q, b_q, ecnt_q} <= {send_a_i, send_b_i, 6'h01};
    end else if (ecnt_q != 6'h00) begin
      ecnt_q <= ecnt_q - 6'h01;
    end
    if (ecnt_q == 6'h01) pcnt_q <= 4'h8;
    else if (pcnt_q != 4'h0) pcnt_q <= pcnt_q - 4'h1;
    char_o <= (pcnt_q != 4'h0);
    // Released lines toggle so a stale character never looks valid
    rd_a_o <= (pcnt_q != 4'h0) ? a_q : ~rd_a_o;
    rd_b_o <= (pcnt_q != 4'h0) ? b_q : ~rd_b_o;
    if (rcnt_q == 6'h00) rcnt_q <= {5'h00, rewind_i};
    else if (rcnt_q != 6'h28) rcnt_q <= rcnt_q + 6'h01;
    else if (!rewind_i) rcnt_q <= 6'h00;
    rstat_o <= (rcnt_q >= 6'h0A) && (rcnt_q < 6'h28);
  end
endmodule

// >>> mtcs_top_tb.sv
`timescale 1ns/1ps
module mtcs_top_tb;
  import mtcs_pkg::*;
  localparam int WR = 40;
  localparam int ER = 200;
  localparam int RD = 40;
  localparam int FWD = 50;
  logic       core_clk_i = 1'b0;
  logic       nrst_i     = 1'b0;
  logic [9:0] call_q     = 10'h000;
  logic [6:0] sys_data_i = 7'h00;
  logic [6:0] snd_a      = 7'h00;
  logic [6:0] snd_b      = 7'h00;
  logic [6:0] tape_rd_a_i, tape_rd_b_i, tape_wr_data_o, sys_data_o;
  logic       tape_char_i, drive_write_status_i, drive_rewind_status_i;
  logic       go_o, backward_o, write_status_o, write_strobe_o, amp_enable_o;
  logic       sys_data_valid_o, first_tm_o, rewind_o, unload_o, error_o, busy_o;
  int         err_total = 0;
  int         n_checks  = 0;
  int         cyc       = 0;
  int         n, nw;
  logic [6:0] ra [3];
  logic [6:0] rb [3];
  logic [6:0] rx [3];
  always #2 core_clk_i = ~core_clk_i;
  mtcs_top #(.WR_DLY(WR), .ER_DLY(ER), .RD_DLY(RD), .EOR_DLY(600),
    .FWD_DLY(FWD)) u_dut (
    .core_clk_i, .nrst_i, .write_call_i(call_q[0]), .read_call_i(call_q[1]),
    .backspace_call_i(call_q[2]), .tape_mark_call_i(call_q[3]),
    .rewind_call_i(call_q[4]), .rewind_unload_call_i(call_q[5]),
    .disconnect_call_i(call_q[6]), .odd_call_i(call_q[7]),
    .erase_call_i(call_q[8]), .sys_data_i, .tape_rd_a_i, .tape_rd_b_i,
    .tape_char_i, .drive_write_status_i, .drive_rewind_status_i, .go_o,
    .backward_o, .write_status_o, .write_strobe_o, .tape_wr_data_o,
    .amp_enable_o, .sys_data_o, .sys_data_valid_o, .first_tm_o, .rewind_o,
    .unload_o, .error_o, .busy_o);
  mtcs_drive_model u_drv (.clk_i(core_clk_i), .write_status_i(write_status_o),
    .write_strobe_i(write_strobe_o), .wr_data_i(tape_wr_data_o),
    .rewind_i(rewind_o), .send_i(call_q[9]), .send_a_i(snd_a),
    .send_b_i(snd_b), .rd_a_o(tape_rd_a_i), .rd_b_o(tape_rd_b_i),
    .char_o(tape_char_i), .wstat_o(drive_write_status_i),
    .rstat_o(drive_rewind_status_i));
  // ----------
  // Access tasks
  // ----------
  function automatic logic [6:0] ch(input logic [5:0] v, input logic odd);
    return {(^v) ^ odd, v};
  endfunction
  function automatic logic sig(input int s);
    case (s)
      0: return write_strobe_o;
      1: return sys_data_valid_o;
      2: return amp_enable_o;
      3: return !busy_o;
      4: return backward_o;
      default: return !rewind_o;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic pulse(input int s);
    @(posedge core_clk_i) call_q[s] <= 1'b1;
    @(posedge core_clk_i) call_q <= 10'h000;
    #1;
  endtask
  // Bounded wait keeps a missing handshake from hanging the run
  task automatic wait_for(input int s, output int k);
    k = 0;
    while (sig(s) !== 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k >= 5000) chk("wait", 7'h01, 7'h00);
  endtask
  task automatic do_write(input int op, input logic [6:0] c0, c1,
                          output int n0);
    logic [6:0] m;
    int         k;
    m = (op == 3) ? 7'h3F : 7'h7F;
    @(posedge core_clk_i) sys_data_i <= c0;
    pulse(op);
    wait_for(0, n0);
    chk("wr_data0", c0 & m, tape_wr_data_o & m);
    if (op != 3) begin
      @(posedge core_clk_i) sys_data_i <= c1;
      tick(1);
      wait_for(0, k);
      chk("wr_data1", c1, tape_wr_data_o);
      pulse(6);
    end
    tick(1);
    wait_for(0, k);
    chk("chk_char", (op == 3) ? c0 : c0 ^ c1, tape_wr_data_o);
    wait_for(3, k);
  endtask
  task automatic do_read(input int op);
    int   k;
    logic ws;
    ws = drive_write_status_i;
    pulse(op);
    if (op == 2) begin
      wait_for(4, k);
      chk("bs_status", 7'h00, {6'h00, write_status_o});
      chk("bs_nudge", 7'h01, {6'h00, !ws || k >= FWD - 2});
    end
    wait_for(2, k);
    if (op == 1) chk("rd_delay", 7'h01, {6'h00, k >= RD - 2});
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i) {snd_a, snd_b} <= {ra[i], rb[i]};
      pulse(9);
      if (op == 1) begin
        wait_for(1, k);
        chk("rd_data", rx[i], sys_data_o);
        if (i == 0) chk("first_tm", 7'h01, {6'h00, first_tm_o});
      end
      tick(op == 1 ? 150 : 300);
    end
    wait_for(3, k);
    if (op == 2) chk("bs_fwd", 7'h00, {6'h00, backward_o});
  endtask
  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------
  // Sequence of operations
  // ----------
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    tick(1);
    chk("reset", 7'h00, {go_o, busy_o, error_o, rewind_o, unload_o,
        backward_o, amp_enable_o});
    do_write(0, ch(6'h01, 1'b0), ch(6'h3E, 1'b0), nw);
    chk("wr_delay", 7'h01, {6'h00, nw >= WR});
    chk("wr_err", 7'h00, {6'h00, error_o});
    do_write(3, {1'b0, TAPE_MARK}, 7'h00, n);
    chk("tm_err", 7'h00, {6'h00, error_o});
    pulse(8);
    do_write(0, ch(6'h22, 1'b0), ch(6'h11, 1'b0), n);
    chk("erase_dly", 7'h01, {6'h00, n >= ER && n > nw});
    pulse(7);
    do_write(0, ch(6'h07, 1'b1), ch(6'h30, 1'b1), n);
    chk("odd_err", 7'h00, {6'h00, error_o});
    do_write(0, ch(6'h07, 1'b0), ch(6'h30, 1'b1), n);
    chk("err_flag", 7'h01, {6'h00, error_o});
    ra[0] = ch(TAPE_MARK, 1'b1);
    rb[0] = ra[0];
    rx[0] = ra[0];
    rb[1] = ch(6'h15, 1'b1);
    ra[1] = rb[1] ^ 7'h40;
    rx[1] = rb[1];
    ra[2] = ch(6'h2A, 1'b1);
    rb[2] = ch(6'h2B, 1'b1);
    rx[2] = ra[2];
    do_read(2);
    do_read(1);
    pulse(4);
    chk("rew_on", 7'h01, {6'h00, rewind_o});
    wait_for(5, n);
    tick(60);
    pulse(5);
    chk("ru_on", 7'h01, {6'h00, rewind_o});
    wait_for(5, n);
    tick(20);
    chk("unload", 7'h01, {6'h00, unload_o});
    test_done();
  end
endmodule
